// >>> include/icr_pkg.sv
`default_nettype none
package icr_pkg;
   // register byte offsets
   localparam logic [7:0] ICR_OFS_CTRL = 8'h00;
   localparam logic [7:0] ICR_OFS_STAT = 8'h04;
   localparam logic [7:0] ICR_OFS_FLAG = 8'h08;
   localparam logic [7:0] ICR_OFS_IEN = 8'h0C;
   localparam logic [7:0] ICR_OFS_THR = 8'h50;
   // control_zero fields
   localparam int ICR_C_EN = 0;
   localparam int ICR_C_MST = 1;
   localparam int ICR_C_GCEN = 2;
   localparam int ICR_C_IRXM = 3;
   localparam int ICR_C_ACK = 4;
   localparam int ICR_C_SCLO = 6;
   localparam int ICR_C_SDAO = 7;
   localparam int ICR_C_SCL = 8;
   localparam int ICR_C_SDA = 9;
   localparam int ICR_C_SWOE = 10;
   localparam logic [15:0] ICR_CTRL_WMASK = 16'h04DF;
   localparam logic [15:0] ICR_CTRL_RST = 16'h0000;
   // bus_fifo_status fields
   localparam int ICR_S_BUSY = 0;
   localparam int ICR_S_RXE = 1;
   localparam int ICR_S_RXF = 2;
   localparam int ICR_S_TXE = 3;
   localparam int ICR_S_TXF = 4;
   localparam int ICR_S_CKMD = 5;
   // event_flags_zero fields
   localparam int ICR_F_DONE = 0;
   localparam int ICR_F_IRXM = 1;
   localparam int ICR_F_GC = 2;
   localparam int ICR_F_AM = 3;
   localparam int ICR_F_RXTH = 4;
   localparam int ICR_F_TXTH = 5;
   localparam int ICR_F_STOP = 6;
   localparam int ICR_F_ADRACK = 7;
   localparam int ICR_F_ARBER = 8;
   localparam int ICR_F_TOER = 9;
   localparam int ICR_F_ADRER = 10;
   localparam int ICR_F_DATER = 11;
   localparam int ICR_F_DNRER = 12;
   localparam int ICR_F_STRTER = 13;
   localparam int ICR_F_STOPER = 14;
   localparam int ICR_F_TXLO = 15;
   localparam logic [15:0] ICR_FLAG_RST = 16'h0030;
   localparam logic [15:0] ICR_FLAG_W1C = 16'hFFCF;
   localparam logic [15:0] ICR_IEN_RST = 16'h0000;
   // threshold register fields
   localparam int ICR_T_RXTH = 0;
   localparam int ICR_T_TXTH = 8;
   localparam int ICR_TH_W = 4;
   localparam logic [3:0] ICR_RXTH_RST = 4'h0;
   localparam logic [3:0] ICR_TXTH_RST = 4'h0;
endpackage
`default_nettype wire

// >>> rtl/icr_regs.sv
// Functional notes
// - override clock bit: 0 drives low, 1 releases
// - ack bit picks ACK or NACK
// - interactive receive flags each received byte
// - general call acknowledged only when enabled
// - role bit: 1 master, 0 slave
// - engine enable, engine pin drive and engine event flags idle unless enable bit set
// - status shows external master driving clock
// - FIFO full and empty status bits
// - busy bit high while bus in use
// - lockout flushes TX FIFO, blocks writes
// - out of sequence STOP error flag
// - out of sequence START error flag
// - slave address match with unprepared FIFO
// - master data NACK error flag
// - master address NACK error flag
// - clock held low too long flag
// - master address ACK flag
// - STOP detected flag
// - TX threshold flag while count at most threshold
// - RX threshold flag while count reaches threshold
// - separate address and general call flags
// - transfer complete flag after final acknowledge
// - override enable hands pins to software
// - TX threshold uses programmed field value
`timescale 1ns/1ps
`default_nettype none
module icr_regs
   import icr_pkg::*;
#(
   parameter int FIFO_DEPTH = 8,
   parameter int CNT_W = 4
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // i2c pins, open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe,
   output logic sda_o,
   output logic sda_oe,
   // protocol engine drive requests
   input wire logic eng_scl_low,
   input wire logic eng_sda_low,
   // protocol engine events, one-cycle pulses, and the tx_preload level
   input wire logic evt_done,
   input wire logic evt_rx_byte,
   input wire logic evt_gc_addr,
   input wire logic evt_own_addr,
   input wire logic evt_fifo_unready,
   input wire logic evt_addr_ack,
   input wire logic evt_addr_nack,
   input wire logic evt_data_nack,
   input wire logic evt_arb_lost,
   input wire logic evt_timeout,
   input wire logic evt_start_err,
   input wire logic tx_preload,
   // fifo fill counts
   input wire logic [CNT_W-1:0] tx_count,
   input wire logic [CNT_W-1:0] rx_count,
   // controls to protocol engine and fifos
   output logic ctrl_enable,
   output logic ctrl_master,
   output logic gc_ack_en,
   output logic irx_enable,
   output logic irx_nack,
   output logic tx_flush,
   output logic tx_write_block,
   output logic irq
);

   function automatic logic [CNT_W-1:0] cnt_of(input logic [3:0] v);
      cnt_of = CNT_W'(v);
   endfunction

   // apb decode
   logic acc;
   logic wr_en;
   logic rd_hit;
   logic pready_r;
   assign acc = psel & penable & pready_r;
   assign wr_en = acc & pwrite;
   assign rd_hit = (paddr == ICR_OFS_CTRL) | (paddr == ICR_OFS_STAT) | (paddr == ICR_OFS_FLAG)
      | (paddr == ICR_OFS_IEN) | (paddr == ICR_OFS_THR);

   // pin synchronisers, value moves when stages two and three agree
   logic [2:0] scl_sy_r;
   logic [2:0] sda_sy_r;
   logic scl_f_r;
   logic sda_f_r;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_sy_r <= 3'h7;
         sda_sy_r <= 3'h7;
      end
      else
      begin
         scl_sy_r <= {scl_sy_r[1:0], scl_i};
         sda_sy_r <= {sda_sy_r[1:0], sda_i};
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_f_r <= 1'b1;
         sda_f_r <= 1'b1;
      end
      else
      begin
         if (scl_sy_r[1] == scl_sy_r[2])
            scl_f_r <= scl_sy_r[2];
         if (sda_sy_r[1] == sda_sy_r[2])
            sda_f_r <= sda_sy_r[2];
      end
   end

   // start and stop detection on filtered pins
   logic scl_p_r;
   logic sda_p_r;
   logic start_det;
   logic stop_det;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
      end
      else
      begin
         scl_p_r <= scl_f_r;
         sda_p_r <= sda_f_r;
      end
   end
   assign start_det = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
   assign stop_det = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;

   // control register
   logic [15:0] ctrl_r;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         ctrl_r <= ICR_CTRL_RST;
      else if (wr_en && paddr == ICR_OFS_CTRL)
         ctrl_r <= pwdata[15:0] & ICR_CTRL_WMASK;
   end

   // threshold register
   logic [ICR_TH_W-1:0] txth_r;
   logic [ICR_TH_W-1:0] rxth_r;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txth_r <= ICR_TXTH_RST;
         rxth_r <= ICR_RXTH_RST;
      end
      else if (wr_en && paddr == ICR_OFS_THR)
      begin
         txth_r <= pwdata[ICR_T_TXTH +: ICR_TH_W];
         rxth_r <= pwdata[ICR_T_RXTH +: ICR_TH_W];
      end
   end

   // enable register
   logic [15:0] ien_r;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         ien_r <= ICR_IEN_RST;
      else if (wr_en && paddr == ICR_OFS_IEN)
         ien_r <= pwdata[15:0];
   end

   // bus busy and external clock drive
   logic busy_r;
   logic ckmd_r;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         busy_r <= 1'b0;
      else if (start_det)
         busy_r <= 1'b1;
      else if (stop_det)
         busy_r <= 1'b0;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         ckmd_r <= 1'b0;
      else
         ckmd_r <= ~scl_f_r & ~scl_oe;
   end

   // fifo status bits
   logic txf_r;
   logic txe_r;
   logic rxf_r;
   logic rxe_r;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txf_r <= 1'b0;
         txe_r <= 1'b1;
         rxf_r <= 1'b0;
         rxe_r <= 1'b1;
      end
      else
      begin
         txf_r <= tx_count == CNT_W'(FIFO_DEPTH);
         txe_r <= tx_count == '0;
         rxf_r <= rx_count == CNT_W'(FIFO_DEPTH);
         rxe_r <= rx_count == '0;
      end
   end

   // gated events
   logic en;
   logic mst;
   logic slv;
   logic [15:0] set_v;
   logic [15:0] clr_v;
   assign en = ctrl_r[ICR_C_EN];
   assign mst = en & ctrl_r[ICR_C_MST];
   assign slv = en & ~ctrl_r[ICR_C_MST];
   always_comb
   begin
      set_v = '0;
      set_v[ICR_F_DONE] = en & evt_done;
      set_v[ICR_F_IRXM] = en & ctrl_r[ICR_C_IRXM] & evt_rx_byte;
      set_v[ICR_F_GC] = slv & ctrl_r[ICR_C_GCEN] & evt_gc_addr;
      set_v[ICR_F_AM] = slv & evt_own_addr;
      set_v[ICR_F_STOP] = stop_det;
      set_v[ICR_F_ADRACK] = mst & evt_addr_ack;
      set_v[ICR_F_ARBER] = mst & evt_arb_lost;
      set_v[ICR_F_TOER] = en & evt_timeout;
      set_v[ICR_F_ADRER] = mst & evt_addr_nack;
      set_v[ICR_F_DATER] = mst & evt_data_nack;
      set_v[ICR_F_DNRER] = slv & evt_fifo_unready & (set_v[ICR_F_AM] | set_v[ICR_F_GC]);
      set_v[ICR_F_STRTER] = en & evt_start_err;
      set_v[ICR_F_STOPER] = stop_det & ~busy_r;
      set_v[ICR_F_TXLO] = ~tx_preload & (set_v[ICR_F_AM] | set_v[ICR_F_GC]);
   end
   assign clr_v = (wr_en && paddr == ICR_OFS_FLAG) ? (pwdata[15:0] & ICR_FLAG_W1C) : 16'h0000;

   // sticky flags, set wins over clear; threshold flags are live
   logic [15:0] flag_r;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         flag_r <= ICR_FLAG_RST;
      else
      begin
         flag_r <= (flag_r & ~clr_v & ICR_FLAG_W1C) | (set_v & ICR_FLAG_W1C);
         flag_r[ICR_F_TXTH] <= tx_count <= cnt_of(txth_r);
         flag_r[ICR_F_RXTH] <= rx_count >= cnt_of(rxth_r);
      end
   end

   // tx flush pulse on lockout
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         tx_flush <= 1'b0;
      else
         tx_flush <= set_v[ICR_F_TXLO];
   end

   // engine controls
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_enable <= 1'b0;
         ctrl_master <= 1'b0;
         gc_ack_en <= 1'b0;
         irx_enable <= 1'b0;
         irx_nack <= 1'b0;
         tx_write_block <= 1'b0;
      end
      else
      begin
         ctrl_enable <= en;
         ctrl_master <= ctrl_r[ICR_C_MST];
         gc_ack_en <= ctrl_r[ICR_C_GCEN];
         irx_enable <= ctrl_r[ICR_C_IRXM];
         irx_nack <= ctrl_r[ICR_C_ACK];
         tx_write_block <= flag_r[ICR_F_TXLO] | set_v[ICR_F_TXLO];
      end
   end

   // pin drive, enable high pulls the line low
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
      else
      begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         if (ctrl_r[ICR_C_SWOE])
         begin
            scl_oe <= ~ctrl_r[ICR_C_SCLO];
            sda_oe <= ~ctrl_r[ICR_C_SDAO];
         end
         else
         begin
            scl_oe <= en & eng_scl_low;
            sda_oe <= en & eng_sda_low;
         end
      end
   end

   // interrupt request
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         irq <= 1'b0;
      else
         irq <= |(flag_r & ien_r);
   end

   // read mux
   logic [31:0] rd_v;
   always_comb
   begin
      rd_v = 32'h0000_0000;
      unique case (paddr)
         ICR_OFS_CTRL:
         begin
            rd_v[15:0] = ctrl_r;
            rd_v[ICR_C_SCL] = scl_f_r;
            rd_v[ICR_C_SDA] = sda_f_r;
         end
         ICR_OFS_STAT:
         begin
            rd_v[ICR_S_BUSY] = busy_r;
            rd_v[ICR_S_RXE] = rxe_r;
            rd_v[ICR_S_RXF] = rxf_r;
            rd_v[ICR_S_TXE] = txe_r;
            rd_v[ICR_S_TXF] = txf_r;
            rd_v[ICR_S_CKMD] = ckmd_r;
         end
         ICR_OFS_FLAG: rd_v[15:0] = flag_r;
         ICR_OFS_IEN: rd_v[15:0] = ien_r;
         ICR_OFS_THR:
         begin
            rd_v[ICR_T_TXTH +: ICR_TH_W] = txth_r;
            rd_v[ICR_T_RXTH +: ICR_TH_W] = rxth_r;
         end
         default: rd_v = 32'h0000_0000;
      endcase
   end

   // apb answer: one wait state
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready_r <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready_r <= psel & penable & ~pready_r;
         prdata <= (psel & penable & ~pready_r & ~pwrite) ? rd_v : 32'h0000_0000;
         pslverr <= psel & penable & ~pready_r & ~rd_hit;
      end
   end
   assign pready = pready_r;

endmodule
`default_nettype wire

// >>> tb/icr_ext_dev.sv
`timescale 1ns/1ps
`default_nettype none
module icr_ext_dev
(
   // open-drain pulls, high pulls the line low
   output logic scl_pull,
   output logic sda_pull
);
   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // data falls while clock high
   task automatic start;
      sda_pull = 1'b1;
      #62.5;
      scl_pull = 1'b1;
      #62.5;
   endtask
   // data rises while clock high
   task automatic stop;
      scl_pull = 1'b1;
      #62.5;
      sda_pull = 1'b1;
      #62.5;
      scl_pull = 1'b0;
      #62.5;
      sda_pull = 1'b0;
      #62.5;
   endtask
endmodule
`default_nettype wire

// >>> tb/icr_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module icr_regs_chk
   import icr_pkg::*;
#(
   parameter int FIFO_DEPTH = 8,
   parameter int CNT_W = 4
)
(
   // clock, reset
   input wire logic sys_clk,
   input wire logic nrst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins, events, controls
   input wire logic scl_o,
   input wire logic sda_o,
   input wire logic evt_own_addr,
   input wire logic tx_preload,
   input wire logic ctrl_enable,
   input wire logic ctrl_master,
   input wire logic gc_ack_en,
   input wire logic irx_enable,
   input wire logic irx_nack,
   input wire logic tx_flush,
   input wire logic tx_write_block,
   input wire logic irq
);
   logic ien_seen_r;
   logic unlock_w;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   assign unlock_w = psel && penable && pready && pwrite && paddr == ICR_OFS_FLAG && pwdata[ICR_F_TXLO];
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
         ien_seen_r <= 1'b0;
      else if (psel && penable && pready && pwrite && paddr == ICR_OFS_IEN)
         ien_seen_r <= 1'b1;
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_ctl_wr;
      psel && penable && pready && pwrite && paddr == ICR_OFS_CTRL;
   endsequence
   property p_wait;
      s_setup |-> ##2 pready;
   endproperty
   a_wait: assert property (p_wait)
      else $error("no answer two cycles after setup");
   property p_stand;
      pready |=> !pready;
   endproperty
   a_stand: assert property (p_stand)
      else $error("pready held too long");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err)
      else $error("error without pready");
   property p_od;
      scl_o == 1'b0 && sda_o == 1'b0;
   endproperty
   a_od: assert property (p_od)
      else $error("pin driven high");
   property p_ctl;
      s_ctl_wr |-> ##2 {irx_nack, irx_enable, gc_ack_en, ctrl_master, ctrl_enable} == $past(pwdata[4:0], 2);
   endproperty
   a_ctl: assert property (p_ctl)
      else $error("control outputs differ from write");
   property p_lock;
      evt_own_addr && ctrl_enable && !ctrl_master && !tx_preload |-> ##[1:2] tx_write_block;
   endproperty
   a_lock: assert property (p_lock)
      else $error("address match did not lock");
   property p_flush;
      $rose(tx_write_block) |-> ##[0:1] tx_flush;
   endproperty
   a_flush: assert property (p_flush)
      else $error("lock without flush");
   property p_hold;
      $fell(tx_write_block) |-> $past(unlock_w) || $past(unlock_w, 2);
   endproperty
   a_hold: assert property (p_hold)
      else $error("lock dropped without clear");
   property p_irq;
      !ien_seen_r |-> !irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq with no enable");
endmodule
bind icr_regs icr_regs_chk #(.FIFO_DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_o(scl_o), .sda_o(sda_o), .evt_own_addr(evt_own_addr), .tx_preload(tx_preload),
   .ctrl_enable(ctrl_enable), .ctrl_master(ctrl_master), .gc_ack_en(gc_ack_en),
   .irx_enable(irx_enable), .irx_nack(irx_nack), .tx_flush(tx_flush),
   .tx_write_block(tx_write_block), .irq(irq));
`default_nettype wire

// >>> tb/icr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module icr_regs_tb_top;
   logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, re, tpre, lock, irq;
   logic scl_o, scl_oe, sda_o, sda_oe;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [1:0] eng;
   logic [10:0] ev;
   logic [3:0] txc, rxc;
   logic [4:0] cq;
   wire xs, xd, scl_i, sda_i;
   int n_fail, n_tests;
   assign scl_i = !(scl_oe || xs);
   assign sda_i = !(sda_oe || xd);
   icr_ext_dev X (.scl_pull(xs), .sda_pull(xd));
   icr_regs #(.FIFO_DEPTH(8), .CNT_W(4)) DUT (
      .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
      .sda_oe(sda_oe), .eng_scl_low(eng[1]), .eng_sda_low(eng[0]), .evt_done(ev[0]),
      .evt_rx_byte(ev[1]), .evt_gc_addr(ev[2]), .evt_own_addr(ev[3]), .evt_fifo_unready(ev[4]),
      .evt_addr_ack(ev[5]), .evt_addr_nack(ev[6]), .evt_data_nack(ev[7]), .evt_arb_lost(ev[8]),
      .evt_timeout(ev[9]), .evt_start_err(ev[10]), .tx_preload(tpre), .tx_count(txc),
      .rx_count(rxc), .ctrl_enable(cq[0]), .ctrl_master(cq[1]), .gc_ack_en(cq[2]),
      .irx_enable(cq[3]), .irx_nack(cq[4]), .tx_flush(), .tx_write_block(lock), .irq(irq));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task report_and_stop;
      $display("checks %0d errors %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), rv, e);
   endtask
   task settle;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask
   task ev_chk(input logic [10:0] m, input logic [15:0] x);
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 11'h000;
      rc(8'h08, {16'h0, x | 16'h0030});
      chk("lock", {31'h0, lock}, {31'h0, x[15]});
      wr(8'h08, 32'h0);
      rc(8'h08, {16'h0, x | 16'h0030});
      wr(8'h08, 32'hFFFF);
      rc(8'h08, 32'h30);
   endtask
   task t_rst;
      rc(8'h00, 32'h300);
      rc(8'h04, 32'h0A);
      rc(8'h08, 32'h30);
      rc(8'h0C, 32'h0);
      rc(8'h40, 32'h0);
      chk("slverr", {31'h0, re}, 32'h1);
   endtask
   task t_ctl;
      wr(8'h00, 32'h1F);
      settle;
      chk("ctl", {27'h0, cq}, 32'h1F);
      rc(8'h00, 32'h31F);
      wr(8'h00, 32'hFFFFFFFF);
      rc(8'h00, 32'h7DF);
      wr(8'h00, 32'h0);
      settle;
      chk("ctl", {27'h0, cq}, 32'h0);
   endtask
   task t_th;
      txc <= 4'h8;
      rxc <= 4'h8;
      settle;
      rc(8'h04, 32'h14);
      rc(8'h08, 32'h10);
      wr(8'h50, 32'h809);
      rc(8'h08, 32'h20);
      txc <= 4'h0;
      rxc <= 4'h0;
      wr(8'h50, 32'h0);
   endtask
   task t_ev;
      wr(8'h00, 32'h3);
      ev_chk(11'h001, 16'h0001);
      ev_chk(11'h020, 16'h0080);
      ev_chk(11'h040, 16'h0400);
      ev_chk(11'h080, 16'h0800);
      ev_chk(11'h200, 16'h0200);
      ev_chk(11'h400, 16'h2000);
      ev_chk(11'h100, 16'h0100);
      ev_chk(11'h008, 16'h0000);
      wr(8'h00, 32'h1);
      ev_chk(11'h004, 16'h0000);
      ev_chk(11'h008, 16'h8008);
      ev_chk(11'h018, 16'h9008);
      tpre <= 1'b1;
      ev_chk(11'h008, 16'h0008);
      tpre <= 1'b0;
      wr(8'h00, 32'h5);
      ev_chk(11'h004, 16'h8004);
      wr(8'h00, 32'h9);
      ev_chk(11'h002, 16'h0002);
      wr(8'h00, 32'h0);
      ev_chk(11'h001, 16'h0000);
   endtask
   task t_irq;
      wr(8'h0C, 32'h10);
      settle;
      chk("irq", {31'h0, irq}, 32'h1);
      wr(8'h0C, 32'h1);
      settle;
      chk("irq", {31'h0, irq}, 32'h0);
      wr(8'h00, 32'h1);
      ev_chk(11'h001, 16'h0001);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(8'h0C, 32'h0);
   endtask
   task t_pins;
      X.start();
      settle;
      rc(8'h04, 32'h2B);
      X.stop();
      settle;
      rc(8'h04, 32'h0A);
      rc(8'h08, 32'h70);
      wr(8'h08, 32'hFFFF);
      X.stop();
      settle;
      rc(8'h08, 32'h4070);
      wr(8'h08, 32'hFFFF);
   endtask
   task t_sw;
      wr(8'h00, 32'h400);
      settle;
      chk("oe", {30'h0, scl_oe, sda_oe}, 32'h3);
      rc(8'h00, 32'h400);
      wr(8'h00, 32'h480);
      settle;
      chk("oe", {30'h0, scl_oe, sda_oe}, 32'h2);
      wr(8'h00, 32'h441);
      settle;
      chk("oe", {30'h0, scl_oe, sda_oe}, 32'h1);
      wr(8'h00, 32'h1);
      eng <= 2'b11;
      settle;
      chk("oe", {30'h0, scl_oe, sda_oe}, 32'h3);
   endtask
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      report_and_stop;
   end
   initial
   begin
      {nrst, psel, penable, pwrite, tpre} = 5'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      {eng, ev, txc, rxc} = 21'h0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      t_rst;
      t_ctl;
      t_th;
      t_ev;
      t_irq;
      t_pins;
      t_sw;
      report_and_stop;
   end
endmodule
`default_nettype wire
